// ### common/tsw_cpu_if.sv
// request and answer between the cpu port and the switch core
`timescale 1ns/1ps
interface tsw_cpu_if;
    logic req;
    logic we;
    logic [7:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    modport port (output req, output we, output addr, output wdata, input rdata);
    modport core (input req, input we, input addr, input wdata, output rdata);
endinterface : tsw_cpu_if

// ### common/tsw_pkg.sv
// shared constants for the tdm time-slot switch
package tsw_pkg;
    localparam int STREAMS = 16;
    localparam int CHANNELS = 2048;
    // bit-rate codes
    localparam logic [1:0] RATE_2M = 2'h0;
    localparam logic [1:0] RATE_4M = 2'h1;
    localparam logic [1:0] RATE_8M = 2'h2;
    // last bit index of a frame: 32, 64 or 128 channels of 8 bits
    localparam logic [9:0] FBITS_2M = 10'h0FF;
    localparam logic [9:0] FBITS_4M = 10'h1FF;
    localparam logic [9:0] FBITS_8M = 10'h3FF;
    // frame timing
    localparam int FRAME_NS = 125000;
    localparam int CLK_PERIOD_NS = 40;
    localparam int FRAME_CYCLES = FRAME_NS / CLK_PERIOD_NS;
    localparam logic [11:0] FRAME_LOSS_CYCLES = 12'(FRAME_CYCLES + FRAME_CYCLES / 8);
    // run of equal frame-pin samples that marks the idle level
    localparam logic [3:0] POL_RUN = 4'hF;
    // register offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_PTR = 8'h01;
    localparam logic [7:0] REG_CM = 8'h02;
    localparam logic [7:0] REG_BLK_CNT = 8'h03;
    localparam logic [7:0] REG_BLK_VAL = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h05;
    localparam logic [7:0] REG_MEAS = 8'h06;
    localparam logic [3:0] REG_OFS_PAGE = 4'h1;
    // control fields
    localparam int CTRL_BLK = 2;
    localparam logic [1:0] CTRL_RATE_RST = 2'h0;
    // connection memory fields
    localparam int CM_CONST = 11;
    localparam int CM_MSG = 12;
    localparam int CM_HIZ = 13;
endpackage : tsw_pkg

// ### verif/tsw_serial_peer.sv
// serial-side partner: free bit clock, frame pulse, measure edge and stream data
`timescale 1ns/1ps
module tsw_serial_peer (
    input wire logic clock_in,
    output logic serial_clock_out,
    output logic frame_pulse_out,
    output logic measure_out,
    output logic [15:0] serial_stream_out
);
    logic [3:0] div = 4'h0;
    logic [7:0] bit_cnt = 8'h00;
    always @(posedge clock_in) begin
        div <= (div == 4'hB) ? 4'h0 : div + 4'h1;
        bit_cnt <= (div == 4'hB) ? bit_cnt + 8'h01 : bit_cnt;
    end
    // bit clock near the lowest rate
    assign serial_clock_out = (div < 4'h6);
    // frame of 256 bits, active-low pulse on bit 0
    assign frame_pulse_out = (bit_cnt != 8'h00);
    assign measure_out = bit_cnt[5];
    assign serial_stream_out = {16{bit_cnt[3]}};
endmodule : tsw_serial_peer

// ### verif/tsw_sva.sv
// port assertions for the time-slot switch top
`timescale 1ns/1ps
module tsw_sva (
    // clock and resets
    input wire logic clock_in,
    input wire logic nrst_in,
    input wire logic device_reset_n_in,
    // watched inputs
    input wire logic output_drive_enable_in,
    input wire logic test_mode_select_in,
    input wire logic chip_select_n_in,
    input wire logic strobe_or_read_n_in,
    input wire logic rw_or_write_in,
    // watched outputs
    input wire logic [15:0] serial_stream_oe_out,
    input wire logic data_bus_oe_out,
    input wire logic transfer_ack_n_out,
    input wire logic transfer_ack_oe_out
);
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!nrst_in);
    a_ack_after_take: assert property ($fell(chip_select_n_in) && strobe_or_read_n_in
        |-> ##3 transfer_ack_oe_out) else $error("ack not given");
    a_ack_needs_cs: assert property ($rose(transfer_ack_oe_out)
        |-> !$past(chip_select_n_in, 3)) else $error("ack without select");
    a_ack_release: assert property ($rose(chip_select_n_in) |=> !transfer_ack_oe_out)
        else $error("ack held after release");
    a_ack_pin_low: assert property (transfer_ack_oe_out |-> !transfer_ack_n_out)
        else $error("ack pin not low");
    a_read_drives: assert property ($rose(data_bus_oe_out)
        |-> $past(rw_or_write_in, 3)) else $error("bus driven on write");
    a_idle_no_drive: assert property (chip_select_n_in [*2]
        |-> !data_bus_oe_out && !transfer_ack_oe_out) else $error("drive while idle");
    a_ode_hiz: assert property ((!output_drive_enable_in && !test_mode_select_in) [*2]
        |=> serial_stream_oe_out == 16'h0000) else $error("serial driven while disabled");
    a_dev_reset: assert property (!device_reset_n_in
        |-> serial_stream_oe_out == 16'h0000 && !data_bus_oe_out) else $error("reset ignored");
endmodule : tsw_sva

// ### verif/tsw_switch_tb_top.sv
// self-checking bench for the time-slot switch top
`timescale 1ns/1ps
module tsw_switch_tb_top;
    import tsw_pkg::*;
    logic clock_in, nrst_in, device_reset_n_in, sclk, fp, fm, output_drive_enable, tms, trst_n;
    logic cs_n, stb, rw, dboe, ack_n, ack_oe;
    logic [7:0] addr, lo_in, lo_out, hi_in, hi_out;
    logic [15:0] sin, sout, soe, q;
    int fails = 0;
    int total_checks = 0;
    logic [7:0] ra [5] = '{8'h01, 8'h10, 8'h1F, 8'h40, 8'h00};
    logic [15:0] wd [5] = '{16'h0123, 16'h0155, 16'h03FF, 16'hBEEF, 16'h0002};
    logic [15:0] re [5] = '{16'h0123, 16'h0155, 16'h03FF, 16'h0000, 16'h0002};
    tsw_serial_peer u_peer (.clock_in(clock_in), .serial_clock_out(sclk), .frame_pulse_out(fp),
        .measure_out(fm), .serial_stream_out(sin));
    tsw_switch u_dut (.clock_in(clock_in), .nrst_in(nrst_in),
        .device_reset_n_in(device_reset_n_in), .serial_clock_in(sclk), .frame_pulse_in(fp),
        .frame_measure_or_aux_clock_in(fm), .compat_mode_in(1'b0), .serial_stream_in(sin),
        .output_drive_enable_in(output_drive_enable), .serial_stream_out(sout), .serial_stream_oe_out(soe),
        .bus_style_select_in(1'b0), .read_strobe_style_in(1'b0), .cpu_address_in(addr),
        .addr_latch_in(1'b0), .strobe_or_read_n_in(stb), .rw_or_write_in(rw),
        .chip_select_n_in(cs_n), .addr_data_low_byte_in(lo_in), .data_high_byte_in(hi_in),
        .addr_data_low_byte_out(lo_out), .data_high_byte_out(hi_out), .data_bus_oe_out(dboe),
        .transfer_ack_n_out(ack_n), .transfer_ack_oe_out(ack_oe), .test_reset_n_in(trst_n),
        .test_mode_select_in(tms), .internal_tie_low_in(1'b0));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic acc(input logic rd, input logic [7:0] a, input logic [15:0] d);
        int n;
        n = 0;
        @(negedge clock_in);
        addr = a;
        {hi_in, lo_in} = d;
        rw = rd;
        // strobe with chip select, held until acknowledged or nine cycles pass
        cs_n = 1'b0;
        stb = 1'b1;
        while (ack_oe !== 1'b1 && n < 9) begin
            @(negedge clock_in);
            n++;
        end
        chk(16'(ack_oe), 16'h0001);
        q = {hi_out, lo_out};
        cs_n = 1'b1;
        stb = 1'b0;
        repeat (5) @(negedge clock_in);
    endtask : acc
    task automatic wrap_up();
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : wrap_up
    initial begin
        clock_in = 1'b0;
        forever #20 clock_in = ~clock_in;
    end
    initial begin
        #800000;
        fails++;
        wrap_up();
    end
    initial begin
        {nrst_in, device_reset_n_in, cs_n, stb, rw, output_drive_enable, tms, trst_n} = 8'h69;
        {addr, lo_in, hi_in} = 24'h000000;
        repeat (2) @(negedge clock_in);
        nrst_in = 1'b1;
        foreach (ra[i]) begin
            acc(1'b0, ra[i], wd[i]);
            acc(1'b1, ra[i], 16'h0000);
            chk(q, re[i]);
        end
        $display("register rows done");
        acc(1'b0, REG_PTR, 16'h0005);
        acc(1'b0, REG_CM, 16'h2000);
        acc(1'b0, REG_PTR, 16'h0005);
        acc(1'b1, REG_CM, 16'h0000);
        chk(q, 16'h2000);
        acc(1'b1, REG_PTR, 16'h0000);
        chk(q, 16'h0006);
        $display("connection entry done");
        acc(1'b0, REG_PTR, 16'h0010);
        acc(1'b0, REG_BLK_CNT, 16'h0003);
        acc(1'b0, REG_BLK_VAL, 16'h1234);
        acc(1'b0, REG_CTRL, 16'h0004);
        acc(1'b0, REG_PTR, 16'h0013);
        acc(1'b1, REG_CM, 16'h0000);
        chk(q, 16'h1234);
        $display("block fill done");
        chk(soe, 16'h0000);
        tms = 1'b1;
        repeat (3) @(negedge clock_in);
        chk(soe, 16'hFFFF);
        trst_n = 1'b0;
        repeat (3) @(negedge clock_in);
        chk(soe, 16'h0000);
        {tms, trst_n} = 2'h1;
        $display("test mode done");
        // a rate away from the reset value, so the reset check can fail
        acc(1'b0, REG_CTRL, 16'h0001);
        device_reset_n_in = 1'b0;
        @(negedge clock_in);
        chk({soe[14:0], dboe}, 16'h0000);
        device_reset_n_in = 1'b1;
        acc(1'b1, REG_CTRL, 16'h0000);
        chk(q, 16'(CTRL_RATE_RST));
        $display("device reset done");
        // every entry a driven message byte of all ones
        acc(1'b0, REG_PTR, 16'h0000);
        acc(1'b0, REG_BLK_CNT, 16'h07FF);
        acc(1'b0, REG_BLK_VAL, 16'h10FF);
        acc(1'b0, REG_CTRL, 16'h0004);
        repeat (6400) @(negedge clock_in);
        acc(1'b1, REG_STATUS, 16'h0000);
        chk(q, 16'h000A);
        output_drive_enable = 1'b1;
        repeat (3) @(negedge clock_in);
        chk(soe, 16'hFFFF);
        chk(sout, 16'hFFFF);
        output_drive_enable = 1'b0;
        repeat (3) @(negedge clock_in);
        chk(soe, 16'h0000);
        $display("message fill done");
        wrap_up();
    end
endmodule : tsw_switch_tb_top
bind tsw_switch tsw_sva u_sva (.clock_in(clock_in), .nrst_in(nrst_in),
    .device_reset_n_in(device_reset_n_in), .output_drive_enable_in(output_drive_enable_in),
    .test_mode_select_in(test_mode_select_in), .chip_select_n_in(chip_select_n_in),
    .strobe_or_read_n_in(strobe_or_read_n_in), .rw_or_write_in(rw_or_write_in),
    .serial_stream_oe_out(serial_stream_oe_out), .data_bus_oe_out(data_bus_oe_out),
    .transfer_ack_n_out(transfer_ack_n_out), .transfer_ack_oe_out(transfer_ack_oe_out));

// ### verilog/tsw_cpu_port.sv
// parallel processor port: decodes access styles, drives data and acknowledge
`timescale 1ns/1ps
module tsw_cpu_port
    import tsw_pkg::*;
(
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_n_in,
    // processor pins
    input wire logic bus_style_select_in,
    input wire logic read_strobe_style_in,
    input wire logic [7:0] cpu_address_in,
    input wire logic addr_latch_in,
    input wire logic strobe_or_read_n_in,
    input wire logic rw_or_write_in,
    input wire logic chip_select_n_in,
    input wire logic [7:0] addr_data_low_byte_in,
    input wire logic [7:0] data_high_byte_in,
    output logic [7:0] addr_data_low_byte_out,
    output logic [7:0] data_high_byte_out,
    output logic data_bus_oe_out,
    output logic transfer_ack_n_out,
    output logic transfer_ack_oe_out,
    // core side
    tsw_cpu_if.port bus
);
    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_LATCH, ST_HOLD} tsw_port_st_t;
    tsw_port_st_t state;
    logic rd_style;
    logic active;
    logic is_read;
    logic rd_q;
    logic [7:0] addr_q;

    always_comb begin
        rd_style = bus_style_select_in & read_strobe_style_in;
        active = !chip_select_n_in & (rd_style ? (!strobe_or_read_n_in | !rw_or_write_in)
                                                : strobe_or_read_n_in);
        is_read = rd_style ? !strobe_or_read_n_in : rw_or_write_in;
    end

    // multiplexed address captured while the latch pin is high
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            addr_q <= 8'h00;
        end else if (bus_style_select_in && addr_latch_in) begin
            addr_q <= addr_data_low_byte_in;
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state <= ST_IDLE;
            bus.req <= 1'b0;
            bus.we <= 1'b0;
            bus.addr <= 8'h00;
            bus.wdata <= 16'h0000;
            rd_q <= 1'b0;
            addr_data_low_byte_out <= 8'h00;
            data_high_byte_out <= 8'h00;
            data_bus_oe_out <= 1'b0;
            transfer_ack_n_out <= 1'b0;
            transfer_ack_oe_out <= 1'b0;
        end else begin
            bus.req <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (active) begin
                        bus.req <= 1'b1;
                        bus.we <= !is_read;
                        // bus-mode pin picks the address source
                        bus.addr <= bus_style_select_in ? addr_q : cpu_address_in;
                        bus.wdata <= {data_high_byte_in, addr_data_low_byte_in};
                        rd_q <= is_read;
                        state <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    state <= ST_LATCH;
                end
                ST_LATCH: begin
                    if (rd_q) begin
                        addr_data_low_byte_out <= bus.rdata[7:0];
                        data_high_byte_out <= bus.rdata[15:8];
                        data_bus_oe_out <= 1'b1;
                    end
                    transfer_ack_oe_out <= 1'b1;
                    state <= ST_HOLD;
                end
                ST_HOLD: begin
                    if (!active) begin
                        data_bus_oe_out <= 1'b0;
                        transfer_ack_oe_out <= 1'b0;
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end
endmodule : tsw_cpu_port

// ### verilog/tsw_switch.sv
// time-slot switch core: serial streams, frame timing, memories, registers
`timescale 1ns/1ps
module tsw_switch
    import tsw_pkg::*;
(
    // clock and reset
    input wire logic clock_in,
    input wire logic nrst_in,
    input wire logic device_reset_n_in,
    // serial side
    input wire logic serial_clock_in,
    input wire logic frame_pulse_in,
    input wire logic frame_measure_or_aux_clock_in,
    input wire logic compat_mode_in,
    input wire logic [15:0] serial_stream_in,
    input wire logic output_drive_enable_in,
    output logic [15:0] serial_stream_out,
    output logic [15:0] serial_stream_oe_out,
    // processor port
    input wire logic bus_style_select_in,
    input wire logic read_strobe_style_in,
    input wire logic [7:0] cpu_address_in,
    input wire logic addr_latch_in,
    input wire logic strobe_or_read_n_in,
    input wire logic rw_or_write_in,
    input wire logic chip_select_n_in,
    input wire logic [7:0] addr_data_low_byte_in,
    input wire logic [7:0] data_high_byte_in,
    output logic [7:0] addr_data_low_byte_out,
    output logic [7:0] data_high_byte_out,
    output logic data_bus_oe_out,
    output logic transfer_ack_n_out,
    output logic transfer_ack_oe_out,
    // test pins
    input wire logic test_reset_n_in,
    input wire logic test_mode_select_in,
    input wire logic internal_tie_low_in
);
    function automatic logic [9:0] frame_last(input logic [1:0] rate_code);
        case (rate_code)
            RATE_2M: frame_last = FBITS_2M;
            RATE_4M: frame_last = FBITS_4M;
            default: frame_last = FBITS_8M;
        endcase
    endfunction : frame_last
    logic rst_n;
    assign rst_n = nrst_in & device_reset_n_in;
    tsw_cpu_if bus ();
    tsw_cpu_port u_port (
        .clock_in(clock_in), .rst_n_in(rst_n), .bus_style_select_in(bus_style_select_in),
        .read_strobe_style_in(read_strobe_style_in), .cpu_address_in(cpu_address_in),
        .addr_latch_in(addr_latch_in), .strobe_or_read_n_in(strobe_or_read_n_in),
        .rw_or_write_in(rw_or_write_in), .chip_select_n_in(chip_select_n_in),
        .addr_data_low_byte_in(addr_data_low_byte_in), .data_high_byte_in(data_high_byte_in),
        .addr_data_low_byte_out(addr_data_low_byte_out), .data_high_byte_out(data_high_byte_out),
        .data_bus_oe_out(data_bus_oe_out), .transfer_ack_n_out(transfer_ack_n_out),
        .transfer_ack_oe_out(transfer_ack_oe_out), .bus(bus)
    );
    logic [1:0] rate;
    logic [10:0] ptr, blk_cnt, blk_addr, blk_left;
    logic [15:0] blk_val, cm_rd_q, cm_q, cm2, cmem [CHANNELS];
    logic [9:0] bit_cnt, last, meas_val, ofs [STREAMS], pos [STREAMS];
    logic [3:0] run_cnt, scan, s1_idx, s2_idx;
    logic [11:0] fr_cnt;
    logic [6:0] nxt_ch, s1_ch, in_sh [STREAMS], hold_ch [STREAMS];
    logic [7:0] dm_q, hold_byte [STREAMS], nxt_byte [STREAMS], out_sh [STREAMS];
    logic [7:0] dmem [2 * CHANNELS];
    logic blk_busy, sclk_q, bit_en, fp_q, fp_act, fp_act_q, frame_start, idle_lvl, bank;
    logic frame_lost, fm_q, meas_armed, meas_valid, aux_seen, test_mode, sel_bank, drive;
    logic [STREAMS-1:0] hold_v, nxt_hiz, cur_hiz;
    assign last = frame_last(rate);
    // serial clock rising edge paces bits
    assign bit_en = serial_clock_in & !sclk_q;
    // otherwise opposite of learnt idle level
    assign fp_act = compat_mode_in ? !frame_pulse_in : (frame_pulse_in ^ idle_lvl);
    assign frame_start = bit_en & fp_act & !fp_act_q;
    assign nxt_ch = (bit_cnt[9:3] == last[9:3]) ? 7'h00 : bit_cnt[9:3] + 7'h01;
    assign drive = output_drive_enable_in & !internal_tie_low_in;

    // frame timing and pulse polarity
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            sclk_q <= 1'b0;
            fp_q <= 1'b1;
            fp_act_q <= 1'b0;
            idle_lvl <= 1'b1;
            run_cnt <= 4'h0;
            bit_cnt <= 10'h000;
            bank <= 1'b0;
            fr_cnt <= 12'h000;
            frame_lost <= 1'b1;
        end else begin
            sclk_q <= serial_clock_in;
            fr_cnt <= (fr_cnt == FRAME_LOSS_CYCLES) ? fr_cnt : fr_cnt + 12'h001;
            if (fr_cnt == FRAME_LOSS_CYCLES) begin
                frame_lost <= 1'b1;
            end
            if (bit_en) begin
                fp_q <= frame_pulse_in;
                fp_act_q <= fp_act;
                run_cnt <= (frame_pulse_in != fp_q) ? 4'h0 :
                           (run_cnt == POL_RUN) ? run_cnt : run_cnt + 4'h1;
                // long steady level is the idle level
                if (run_cnt == POL_RUN) begin
                    idle_lvl <= fp_q;
                end
                bit_cnt <= (bit_cnt == last) ? 10'h000 : bit_cnt + 10'h001;
            end
            if (frame_start) begin
                bit_cnt <= 10'h000;
                bank <= !bank;
                fr_cnt <= 12'h000;
                frame_lost <= 1'b0;
            end
        end
    end

    // frame measurement and aux clock watch
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            fm_q <= 1'b0;
            meas_armed <= 1'b0;
            meas_valid <= 1'b0;
            meas_val <= 10'h000;
            aux_seen <= 1'b0;
        end else begin
            fm_q <= frame_measure_or_aux_clock_in;
            if (frame_start) begin
                meas_armed <= !compat_mode_in;
            end
            if (frame_measure_or_aux_clock_in && !fm_q) begin
                if (compat_mode_in) begin
                    aux_seen <= 1'b1;
                end else if (meas_armed && !frame_start) begin
                    meas_val <= bit_cnt;
                    meas_valid <= 1'b1;
                    meas_armed <= 1'b0;
                end
            end
        end
    end

    // test reset clears test mode only
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            test_mode <= 1'b0;
        end else if (!test_reset_n_in) begin
            test_mode <= 1'b0;
        end else begin
            test_mode <= test_mode_select_in;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < STREAMS; gi++) begin : g_pos
            assign pos[gi] = (bit_cnt >= ofs[gi]) ? bit_cnt - ofs[gi]
                                                  : bit_cnt + last + 10'h001 - ofs[gi];
        end
    endgenerate

    // input deserialisers; a new byte wins over the writer's clear
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < STREAMS; i++) begin
                in_sh[i] <= 7'h00;
                hold_byte[i] <= 8'h00;
                hold_ch[i] <= 7'h00;
                hold_v[i] <= 1'b0;
            end
        end else begin
            for (int i = 0; i < STREAMS; i++) begin
                if (scan == 4'(i)) begin
                    hold_v[i] <= 1'b0;
                end
                if (bit_en) begin
                    in_sh[i] <= {in_sh[i][5:0], serial_stream_in[i]};
                    if (pos[i][2:0] == 3'h7) begin
                        hold_byte[i] <= {in_sh[i], serial_stream_in[i]};
                        hold_ch[i] <= pos[i][9:3];
                        hold_v[i] <= 1'b1;
                    end
                end
            end
        end
    end

    // constant delay reads last frame; minimum reads newest copy
    // constant delay keeps a group in one frame
    assign sel_bank = cm_q[CM_CONST] ? !bank : ((cm_q[6:0] < s1_ch) ? bank : !bank);

    // memories: capture writes, block fill, cpu writes, scan reads
    always_ff @(posedge clock_in) begin
        if (hold_v[scan]) begin
            dmem[{bank, scan, hold_ch[scan]}] <= hold_byte[scan];
        end
        // block fill has the write port
        if (blk_busy) begin
            cmem[blk_addr] <= blk_val;
        end else if (bus.req && bus.we && bus.addr == REG_CM) begin
            cmem[ptr] <= bus.wdata;
        end
        cm_rd_q <= cmem[ptr];
        cm_q <= cmem[{scan, nxt_ch}];
        // any source slot feeds any output slot
        dm_q <= dmem[{sel_bank, cm_q[10:0]}];
    end

    // output prefetch pipeline, one stream per cycle
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            scan <= 4'h0;
            s1_idx <= 4'h0;
            s1_ch <= 7'h00;
            s2_idx <= 4'h0;
            cm2 <= 16'h0000;
            nxt_hiz <= '1;
            for (int i = 0; i < STREAMS; i++) begin
                nxt_byte[i] <= 8'hFF;
            end
        end else begin
            scan <= scan + 4'h1;
            s1_idx <= scan;
            s1_ch <= nxt_ch;
            s2_idx <= s1_idx;
            cm2 <= cm_q;
            // message byte and per-channel high impedance
            nxt_byte[s2_idx] <= cm2[CM_MSG] ? cm2[7:0] : dm_q;
            nxt_hiz[s2_idx] <= cm2[CM_HIZ];
        end
    end

    // serialisers and output enables
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            serial_stream_out <= 16'h0000;
            serial_stream_oe_out <= 16'h0000;
            cur_hiz <= '1;
            for (int i = 0; i < STREAMS; i++) begin
                out_sh[i] <= 8'h00;
            end
        end else begin
            for (int i = 0; i < STREAMS; i++) begin
                serial_stream_oe_out[i] <= test_mode | (drive & !cur_hiz[i]);
                if (bit_en) begin
                    if (test_mode) begin
                        serial_stream_out[i] <= serial_stream_in[i];
                    end else if (bit_cnt[2:0] == 3'h7) begin
                        out_sh[i] <= {nxt_byte[i][6:0], 1'b0};
                        serial_stream_out[i] <= nxt_byte[i][7];
                        cur_hiz[i] <= nxt_hiz[i];
                    end else begin
                        out_sh[i] <= {out_sh[i][6:0], 1'b0};
                        serial_stream_out[i] <= out_sh[i][7];
                    end
                end
            end
        end
    end

    // register writes and block engine
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            rate <= CTRL_RATE_RST;
            ptr <= 11'h000;
            blk_cnt <= 11'h000;
            blk_val <= 16'h0000;
            blk_busy <= 1'b0;
            blk_addr <= 11'h000;
            blk_left <= 11'h000;
            for (int i = 0; i < STREAMS; i++) begin
                ofs[i] <= 10'h000;
            end
        end else begin
            if (blk_busy) begin
                blk_addr <= blk_addr + 11'h001;
                blk_left <= blk_left - 11'h001;
                if (blk_left == 11'h000) begin
                    blk_busy <= 1'b0;
                end
            end
            if (bus.req && (bus.addr == REG_CM)) begin
                ptr <= ptr + 11'h001;
            end
            if (bus.req && bus.we) begin
                case (bus.addr)
                    REG_CTRL: begin
                        rate <= bus.wdata[1:0];
                        // start a block fill from the pointer
                        if (bus.wdata[CTRL_BLK] && !blk_busy) begin
                            blk_busy <= 1'b1;
                            blk_addr <= ptr;
                            blk_left <= blk_cnt;
                        end
                    end
                    REG_PTR: ptr <= bus.wdata[10:0];
                    REG_BLK_CNT: blk_cnt <= bus.wdata[10:0];
                    REG_BLK_VAL: blk_val <= bus.wdata;
                    default: begin
                        if (bus.addr[7:4] == REG_OFS_PAGE) begin
                            ofs[bus.addr[3:0]] <= bus.wdata[9:0];
                        end
                    end
                endcase
            end
        end
    end

    // register reads
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            bus.rdata <= 16'h0000;
        end else if (bus.req) begin
            case (bus.addr)
                REG_CTRL: bus.rdata <= {13'h0000, blk_busy, rate};
                REG_PTR: bus.rdata <= {5'h00, ptr};
                REG_CM: bus.rdata <= cm_rd_q;
                REG_BLK_CNT: bus.rdata <= {5'h00, blk_cnt};
                REG_BLK_VAL: bus.rdata <= blk_val;
                REG_STATUS: bus.rdata <= {11'h000, frame_lost, meas_valid, aux_seen,
                                          idle_lvl, blk_busy};
                REG_MEAS: bus.rdata <= {6'h00, meas_val};
                default: begin
                    bus.rdata <= (bus.addr[7:4] == REG_OFS_PAGE) ?
                                 {6'h00, ofs[bus.addr[3:0]]} : 16'h0000;
                end
            endcase
        end
    end
endmodule : tsw_switch
